// >>> rtl/lsst_pkg.sv
package lsst_pkg;

  // ************************************************************
  // alignment penalties in extra cycles, and clamp widths in bits
  // ************************************************************
  localparam logic [1:0] PEN_ODD = 2'h2;
  localparam logic [1:0] PEN_HALF_OFF = 2'h1;
  localparam logic [1:0] PEN_DWORD = 2'h1;
  localparam logic [5:0] HALF_CLAMP = 6'h10;
  localparam logic [5:0] WORD_CLAMP = 6'h20;

  // ************************************************************
  // operations, addressing forms and access sizes
  // ************************************************************
  typedef enum logic [4:0] {
    op_none, op_sat_add_h, op_sat_add_w, op_sat_sub_h, op_sat_sub_w,
    op_sat_rnd_s, op_sat_rnd_u, op_sat_shift_s, op_sat_shift_u,
    op_load_unsigned_byte, op_load_signed_byte, op_load_unsigned_half,
    op_load_signed_half, op_load_word, op_load_doubleword,
    op_load_insert_byte, op_load_insert_half, op_load_swap_signed_half,
    op_load_swap_unsigned_half, op_load_swap_word, op_store_byte,
    op_store_half, op_store_word, op_store_doubleword, op_store_swap_half,
    op_store_swap_word
  } lsst_op_t;

  typedef enum logic [2:0] {
    am_post_inc, am_pre_dec, am_plain, am_disp, am_indexed, am_ext_index
  } lsst_amode_t;

  typedef enum logic [1:0] {sz_byte, sz_half, sz_word, sz_dword} lsst_size_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    lsst_op_t op;
    lsst_amode_t amode;
    logic [3:0] dst;
    logic [3:0] src_a;
    logic [3:0] src_b;
    logic [1:0] src_used;
    logic [3:0] ptr_reg;
    logic [3:0] idx_reg;
    logic [31:0] ptr_val;
    logic [31:0] idx_val;
    logic [31:0] disp;
    logic [4:0] shift_amount;
    logic [4:0] clamp_bit_position;
    logic [1:0] part;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [63:0] sdata;
  } lsst_issue_t;

  typedef struct packed {
    logic valid;
    logic write;
    lsst_size_t size;
    logic [31:0] addr;
    logic [63:0] wdata;
  } lsst_cache_req_t;

  typedef struct packed {
    logic valid;
    logic dword;
    logic [3:0] dst;
    logic [63:0] data;
  } lsst_wb_t;

  typedef struct packed {
    logic valid;
    logic [3:0] dst;
    logic [31:0] data;
  } lsst_ptr_wb_t;

  typedef struct packed {
    logic valid;
    logic q;
    logic n;
    logic z;
  } lsst_flags_t;

endpackage

// >>> rtl/lsst_core.sv
`timescale 1ns/1ps
// How it works
// - saturating ops span both stages, result cycle two
// - saturation flags forwarded one cycle after issue
// - round-shift right then clamp at bit position
// - shift then clamp signed or unsigned
// - dedicated pipe adder forms non-indexed addresses
// - first stage adder forms indexed base plus index
// - first stage adder forms updated pointer value
// - word loads return on cycle two
// - byte and half loads extended, cycle three
// - signed forms sign-extend, unsigned forms zero-extend
// - insert and swap loads fixed in writeback
// - insert byte lands in chosen lane, cycle three
// - swap stores reorder bytes in access stage
// - writers of stored register wait for store
// - unaligned word loads add one or two cycles
// - unaligned word stores delay their access one or two cycles
// - word-aligned doubleword loads add one cycle
// - word-aligned doubleword stores delay their access one cycle
// - aligned doubleword loads all forms cycle two
// - extracted index byte shifted two as offset
module lsst_core
  import lsst_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // issue side
  input wire logic in_valid,
  input lsst_issue_t in_instr,
  output logic in_ready,
  // data cache
  output lsst_cache_req_t cache_req,
  input wire logic [63:0] cache_rdata,
  // register file write ports and flags
  output lsst_wb_t wb,
  output lsst_ptr_wb_t ptr_wb,
  output lsst_flags_t flags
);

  // ************************************************************
  // decoding helpers
  // ************************************************************
  function automatic lsst_size_t size_of(input lsst_op_t op);
    case (op)
      op_load_unsigned_byte, op_load_signed_byte, op_load_insert_byte,
      op_store_byte: size_of = sz_byte;
      op_load_unsigned_half, op_load_signed_half, op_load_insert_half,
      op_load_swap_signed_half, op_load_swap_unsigned_half, op_store_half,
      op_store_swap_half: size_of = sz_half;
      op_load_doubleword, op_store_doubleword: size_of = sz_dword;
      default: size_of = sz_word;
    endcase
  endfunction

  function automatic logic is_mem(input lsst_op_t op);
    is_mem = op >= op_load_unsigned_byte;
  endfunction

  function automatic logic is_store(input lsst_op_t op);
    is_store = op >= op_store_byte;
  endfunction

  // results that need the writeback stage
  function automatic logic is_late(input lsst_op_t op);
    is_late = is_mem(op) && !is_store(op) && op != op_load_word
              && op != op_load_doubleword;
  endfunction

  function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] b,
                                   input logic pair);
    reg_hit = pair ? (a[3:1] == b[3:1]) : (a == b);
  endfunction

  // clamp to a signed or unsigned field of w bits, top bit is saturation
  function automatic logic [32:0] clamp(input logic signed [33:0] v,
                                        input logic [5:0] w, input logic sgn);
    logic signed [33:0] hi;
    logic signed [33:0] lo;
    hi = sgn ? (34'sh1 <<< (w - 6'h1)) - 34'sh1 : (34'sh1 <<< w) - 34'sh1;
    lo = sgn ? -hi - 34'sh1 : 34'sh0;
    if (v > hi)
    begin
      clamp = {1'b1, hi[31:0]};
    end
    else if (v < lo)
    begin
      clamp = {1'b1, lo[31:0]};
    end
    else
    begin
      clamp = {1'b0, v[31:0]};
    end
  endfunction

  // writeback stage fix-up of a right-justified cache answer
  function automatic logic [31:0] wb_fix(input lsst_op_t op, input logic [1:0] part,
                                         input logic [31:0] old, input logic [63:0] d);
    logic [31:0] r;
    r = old;
    case (op)
      op_load_unsigned_byte: r = {24'h0, d[7:0]};
      op_load_signed_byte: r = {{24{d[7]}}, d[7:0]};
      op_load_unsigned_half: r = {16'h0, d[15:0]};
      op_load_signed_half: r = {{16{d[15]}}, d[15:0]};
      op_load_insert_byte: r[part*8 +: 8] = d[7:0];
      op_load_insert_half: r[part[0]*16 +: 16] = d[15:0];
      op_load_swap_signed_half: r = {{16{d[7]}}, d[7:0], d[15:8]};
      op_load_swap_unsigned_half: r = {16'h0, d[7:0], d[15:8]};
      op_load_swap_word: r = {d[7:0], d[15:8], d[23:16], d[31:24]};
      default: r = d[31:0];
    endcase
    wb_fix = r;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic s1_valid_q;
  lsst_issue_t s1_q;
  logic [31:0] addr_q;
  logic [31:0] nptr_q;
  logic [1:0][33:0] lane_q;
  logic [1:0] pen_q;
  logic s2_valid_q;
  lsst_issue_t s2_q;
  logic [63:0] rdata_q;
  lsst_wb_t wb_q;

  // ************************************************************
  // first stage: address adders and saturate pre-arithmetic
  // ************************************************************
  lsst_size_t in_sz;
  logic [31:0] step_c;
  logic [31:0] ls_off_c;
  logic [31:0] ls_sum_c;
  logic [31:0] a1_opnd_c;
  logic [31:0] a1_sum_c;
  logic [31:0] ea_c;
  logic [1:0] pen_c;
  logic [1:0][33:0] half_c;
  logic [1:0][33:0] lane_c;
  logic signed [33:0] shv_c;
  logic rnd_c;

  assign in_sz = size_of(in_instr.op);
  assign step_c = 32'h1 << in_sz;

  // memory pipe adder with operand shift, used for every form but am_indexed
  always_comb
  begin
    case (in_instr.amode)
      am_disp: ls_off_c = in_instr.disp;
      am_ext_index: ls_off_c = {22'h0, in_instr.idx_val[in_instr.part*8 +: 8], 2'h0};
      am_pre_dec: ls_off_c = -step_c;
      default: ls_off_c = 32'h0;
    endcase
  end
  assign ls_sum_c = in_instr.ptr_val + ls_off_c;

  // one first stage adder serves indexed sums and pointer updates
  always_comb
  begin
    case (in_instr.amode)
      am_indexed: a1_opnd_c = in_instr.idx_val << in_instr.shift_amount[1:0];
      am_pre_dec: a1_opnd_c = -step_c;
      default: a1_opnd_c = step_c;
    endcase
  end
  assign a1_sum_c = in_instr.ptr_val + a1_opnd_c;
  assign ea_c = (in_instr.amode == am_indexed) ? a1_sum_c : ls_sum_c;

  // split accesses cost extra cycles; odd addresses need the worst split
  always_comb
  begin
    pen_c = 2'h0;
    if (is_mem(in_instr.op) && in_sz >= sz_word && ea_c[1:0] != 2'h0)
    begin
      pen_c = ea_c[0] ? PEN_ODD : PEN_HALF_OFF;
    end
    else if (is_mem(in_instr.op) && in_sz == sz_dword && ea_c[2])
    begin
      pen_c = PEN_DWORD;
    end
  end

  // halfword lanes of the saturating add and subtract
  generate
    for (genvar l = 0; l < 2; l++)
    begin : g_half
      logic signed [33:0] ha;
      logic signed [33:0] hb;
      assign ha = 34'(signed'(in_instr.opa[l*16 +: 16]));
      assign hb = 34'(signed'(in_instr.opb[l*16 +: 16]));
      assign half_c[l] = (in_instr.op == op_sat_add_h) ? ha + hb : ha - hb;
    end
  endgenerate

  assign shv_c = 34'(signed'(in_instr.opa)) >>> in_instr.shift_amount;
  assign rnd_c = (in_instr.shift_amount != 5'h0)
                 && in_instr.opa[in_instr.shift_amount - 5'h1];

  always_comb
  begin
    lane_c = half_c;
    case (in_instr.op)
      op_sat_add_w: lane_c[0] = 34'(signed'(in_instr.opa)) + 34'(signed'(in_instr.opb));
      op_sat_sub_w: lane_c[0] = 34'(signed'(in_instr.opa)) - 34'(signed'(in_instr.opb));
      op_sat_rnd_s, op_sat_rnd_u: lane_c[0] = shv_c + 34'(rnd_c);
      op_sat_shift_s, op_sat_shift_u: lane_c[0] = shv_c;
      default: lane_c[0] = half_c[0];
    endcase
  end

  // ************************************************************
  // second stage: saturation and forwarded flags
  // ************************************************************
  logic [1:0][32:0] hclamp_c;
  logic [32:0] wclamp_c;
  logic [5:0] cpos_c;
  logic csgn_c;
  logic [31:0] sat_res_c;
  logic sat_q_c;
  logic s1_leave;

  generate
    for (genvar l = 0; l < 2; l++)
    begin : g_hclamp
      assign hclamp_c[l] = clamp(lane_q[l], HALF_CLAMP, 1'b1);
    end
  endgenerate

  // a clamp position of zero is taken as the full word
  assign cpos_c = (s1_q.clamp_bit_position == 5'h0) ? WORD_CLAMP
                  : {1'b0, s1_q.clamp_bit_position};
  assign csgn_c = s1_q.op != op_sat_rnd_u && s1_q.op != op_sat_shift_u;

  always_comb
  begin
    case (s1_q.op)
      op_sat_add_h, op_sat_sub_h: wclamp_c = {hclamp_c[1][32] | hclamp_c[0][32],
                                              hclamp_c[1][15:0], hclamp_c[0][15:0]};
      op_sat_add_w, op_sat_sub_w: wclamp_c = clamp(lane_q[0], WORD_CLAMP, 1'b1);
      default: wclamp_c = clamp(lane_q[0], cpos_c, csgn_c);
    endcase
  end
  assign sat_q_c = wclamp_c[32];
  assign sat_res_c = wclamp_c[31:0];
  assign s1_leave = s1_valid_q && pen_q == 2'h0;

  // flags leave straight from the clamp so the next instruction sees them
  assign flags.valid = s1_leave && !is_mem(s1_q.op) && s1_q.op != op_none;
  assign flags.q = sat_q_c;
  assign flags.n = sat_res_c[31];
  assign flags.z = sat_res_c == 32'h0;

  // ************************************************************
  // interlocks
  // ************************************************************
  logic [3:0][3:0] rd_regs;
  logic [3:0] rd_use;
  logic in_wr_dst;
  logic in_wr_ptr;
  logic in_pair;
  logic s1_pair;
  logic hz_c;

  assign rd_regs = {in_instr.idx_reg, in_instr.ptr_reg, in_instr.src_b, in_instr.src_a};
  assign rd_use = {is_mem(in_instr.op) && (in_instr.amode == am_indexed
                   || in_instr.amode == am_ext_index),
                   is_mem(in_instr.op), in_instr.src_used};
  assign in_wr_dst = !is_store(in_instr.op) && in_instr.op != op_none;
  assign in_wr_ptr = is_mem(in_instr.op)
                     && (in_instr.amode == am_post_inc || in_instr.amode == am_pre_dec);
  assign in_pair = in_sz == sz_dword;
  assign s1_pair = size_of(s1_q.op) == sz_dword;

  always_comb
  begin
    hz_c = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      // a read waits until its producer has shown its result
      if (rd_use[i] && s1_valid_q && !is_store(s1_q.op)
          && reg_hit(rd_regs[i], s1_q.dst, s1_pair))
        hz_c = 1'b1;
      if (rd_use[i] && s1_valid_q && is_mem(s1_q.op)
          && (s1_q.amode == am_post_inc || s1_q.amode == am_pre_dec)
          && rd_regs[i] == s1_q.ptr_reg)
        hz_c = 1'b1;
      if (rd_use[i] && s2_valid_q && reg_hit(rd_regs[i], s2_q.dst, 1'b0))
        hz_c = 1'b1;
    end
    // a store still in the access stage keeps its source register
    if (s1_valid_q && is_store(s1_q.op)
        && ((in_wr_dst && reg_hit(in_instr.dst, s1_q.src_a, in_pair | s1_pair))
            || (in_wr_ptr && reg_hit(in_instr.ptr_reg, s1_q.src_a, s1_pair))))
      hz_c = 1'b1;
    // one write port: an early result may not collide with a late one
    if (s1_valid_q && is_late(s1_q.op) && in_wr_dst && !is_late(in_instr.op))
      hz_c = 1'b1;
  end

  // the stage holds while an alignment penalty runs down
  assign in_ready = pen_q == 2'h0 && !hz_c;

  // ************************************************************
  // pipeline registers
  // ************************************************************
  // first stage capture, held while a penalty is pending
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_valid_q <= 1'b0;
      s1_q <= '0;
      addr_q <= 32'h0;
      nptr_q <= 32'h0;
      lane_q <= '0;
    end
    else if (pen_q == 2'h0)
    begin
      s1_valid_q <= in_valid && in_ready;
      if (in_valid && in_ready)
      begin
        s1_q <= in_instr;
        addr_q <= ea_c;
        nptr_q <= a1_sum_c;
        lane_q <= lane_c;
      end
    end
  end

  // penalty counter loaded on issue
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pen_q <= 2'h0;
    else if (in_valid && in_ready)
      pen_q <= pen_c;
    else if (pen_q != 2'h0)
      pen_q <= pen_q - 2'h1;
  end

  // writeback stage for results that need extension or rearranging
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s2_valid_q <= 1'b0;
      s2_q <= '0;
      rdata_q <= 64'h0;
    end
    else
    begin
      s2_valid_q <= s1_leave && is_late(s1_q.op);
      if (s1_leave)
      begin
        s2_q <= s1_q;
        rdata_q <= cache_rdata;
      end
    end
  end

  // single result port: early results from stage one, late from stage two
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wb_q <= '0;
    else if (s1_leave && !is_store(s1_q.op) && !is_late(s1_q.op)
             && s1_q.op != op_none)
    begin
      wb_q.valid <= 1'b1;
      wb_q.dword <= s1_pair;
      wb_q.dst <= s1_q.dst;
      if (!is_mem(s1_q.op))
        wb_q.data <= {32'h0, sat_res_c};
      else if (s1_pair)
        wb_q.data <= cache_rdata;
      else
        wb_q.data <= {32'h0, cache_rdata[31:0]};
    end
    else if (s2_valid_q)
    begin
      wb_q.valid <= 1'b1;
      wb_q.dword <= 1'b0;
      wb_q.dst <= s2_q.dst;
      wb_q.data <= {32'h0, wb_fix(s2_q.op, s2_q.part, s2_q.opa, rdata_q)};
    end
    else
      wb_q.valid <= 1'b0;
  end
  assign wb = wb_q;

  // ************************************************************
  // cache request and pointer update, issued as the access stage ends
  // ************************************************************
  assign cache_req.valid = s1_leave && is_mem(s1_q.op);
  assign cache_req.write = is_store(s1_q.op);
  assign cache_req.size = size_of(s1_q.op);
  assign cache_req.addr = addr_q;
  always_comb
  begin
    case (s1_q.op)
      op_store_swap_half: cache_req.wdata = {48'h0, s1_q.sdata[7:0], s1_q.sdata[15:8]};
      op_store_swap_word: cache_req.wdata = {32'h0, s1_q.sdata[7:0], s1_q.sdata[15:8],
                                             s1_q.sdata[23:16], s1_q.sdata[31:24]};
      default: cache_req.wdata = s1_q.sdata;
    endcase
  end

  assign ptr_wb.valid = s1_leave && is_mem(s1_q.op)
                        && (s1_q.amode == am_post_inc || s1_q.amode == am_pre_dec);
  assign ptr_wb.dst = s1_q.ptr_reg;
  assign ptr_wb.data = nptr_q;

endmodule

// >>> testbench/lsst_cache_model.sv
`timescale 1ns/1ps
// ************************************************************
// data cache stand-in
// ************************************************************
module lsst_cache_model
  import lsst_pkg::*;
(
  // clock
  input wire logic clk,
  // access side
  input lsst_cache_req_t cache_req,
  output logic [63:0] cache_rdata
);
  logic [31:0] junk_q = 32'h0;
  // idle data churns every cycle so a stale sample never looks right
  always @(posedge clk)
  begin
    junk_q <= junk_q + 32'h9e37;
  end
  // answer in the same cycle; each item is a known function of its address
  assign cache_rdata = (cache_req.valid && !cache_req.write) ?
    {cache_req.addr + 32'h11111111, cache_req.addr ^ 32'h8c8c8c8c} : {junk_q, ~junk_q};
endmodule

// >>> testbench/lsst_core_assertions.sv
`timescale 1ns/1ps
// ************************************************************
// timing checker on the core ports
// ************************************************************
module lsst_core_assertions
  import lsst_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // issue side
  input wire logic in_valid,
  input lsst_issue_t in_instr,
  input wire logic in_ready,
  // cache and results
  input lsst_cache_req_t cache_req,
  input wire logic [63:0] cache_rdata,
  input lsst_wb_t wb,
  input lsst_ptr_wb_t ptr_wb,
  input lsst_flags_t flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic go;
  logic sat;
  logic [31:0] ea;
  logic [31:0] swp;
  // issue qualifiers; ea is the displacement address, swp the swapped store word
  assign go = in_valid && in_ready;
  assign sat = in_instr.op inside {[op_sat_add_h:op_sat_shift_u]};
  assign ea = in_instr.ptr_val + in_instr.disp;
  assign swp = {in_instr.sdata[7:0], in_instr.sdata[15:8], in_instr.sdata[23:16],
    in_instr.sdata[31:24]};

  a_sat_flag_one: assert property (go && sat |=> flags.valid)
    else $error("saturation flags late");
  a_sat_result_two: assert property (go && sat |-> ##2 wb.valid)
    else $error("saturation result late");
  a_word_load_two: assert property (go && in_instr.op == op_load_word &&
    in_instr.amode == am_disp && ea[1:0] == 2'h0 |=> cache_req.valid &&
    cache_req.addr == $past(ea) ##1 wb.valid)
    else $error("aligned word load timing wrong");
  a_byte_load_three: assert property (go && in_instr.op inside
    {op_load_unsigned_byte, op_load_signed_byte} |-> ##3 wb.valid)
    else $error("byte load result late");
  a_sign_extend: assert property (go && in_instr.op == op_load_signed_byte
    |-> ##3 wb.data[31:8] == {24{wb.data[7]}})
    else $error("signed byte not extended");
  a_index_addr: assert property (go && in_instr.amode == am_indexed &&
    in_instr.op == op_load_unsigned_byte |=> cache_req.valid && cache_req.addr ==
    $past(in_instr.ptr_val) + ($past(in_instr.idx_val) << $past(in_instr.shift_amount)))
    else $error("indexed address wrong");
  a_post_inc_ptr: assert property (go && in_instr.amode == am_post_inc &&
    in_instr.op == op_load_doubleword && in_instr.ptr_val[2:0] == 3'h0
    |=> ptr_wb.valid && ptr_wb.data == $past(in_instr.ptr_val) + 32'h8)
    else $error("post increment pointer wrong");
  a_odd_load_wait: assert property (go && in_instr.op == op_load_word &&
    in_instr.amode == am_disp && ea[0] |=> (!cache_req.valid)[*2] ##1 cache_req.valid
    ##1 wb.valid)
    else $error("odd word load timing wrong");
  a_odd_store_wait: assert property (go && in_instr.op == op_store_word &&
    in_instr.amode == am_disp && ea[0] |=> (!in_ready)[*2])
    else $error("odd word store issued early");
  a_dword_skew: assert property (go && in_instr.op == op_load_doubleword &&
    in_instr.amode == am_disp && ea[2:0] == 3'h4 |=> !cache_req.valid ##1
    cache_req.valid ##1 wb.valid && wb.dword)
    else $error("word aligned doubleword timing wrong");
  a_swap_store: assert property (go && in_instr.op == op_store_swap_word &&
    in_instr.amode == am_disp && ea[1:0] == 2'h0 |=> cache_req.valid && cache_req.write
    && cache_req.size == sz_word && cache_req.wdata[31:0] == $past(swp))
    else $error("swap store data wrong");

  // main scenarios reached
  c_sat: cover property (go && sat);
  c_odd_load: cover property (go && in_instr.op == op_load_word && ea[0]);
  c_store: cover property (cache_req.valid && cache_req.write);
endmodule

bind lsst_core lsst_core_assertions lsst_core_assertions_inst (.clk(clk), .rst_n(rst_n),
  .in_valid(in_valid), .in_instr(in_instr), .in_ready(in_ready), .cache_req(cache_req),
  .cache_rdata(cache_rdata), .wb(wb), .ptr_wb(ptr_wb), .flags(flags));

// >>> testbench/load_store_saturate_timing_tb_top.sv
`timescale 1ns/1ps
module load_store_saturate_timing_tb_top
  import lsst_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n;
  logic in_valid;
  lsst_issue_t in_instr;
  logic in_ready;
  lsst_cache_req_t cache_req;
  logic [63:0] cache_rdata;
  lsst_wb_t wb;
  lsst_ptr_wb_t ptr_wb;
  lsst_flags_t flags;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_iss;
  int lat;
  int flat;
  logic [2:0] fq;
  logic [63:0] wd;

  // ************************************************************
  // clock, cycle count and instances
  // ************************************************************
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  lsst_core lsst_core_inst (.clk(clk), .rst_n(rst_n), .in_valid(in_valid),
    .in_instr(in_instr), .in_ready(in_ready), .cache_req(cache_req),
    .cache_rdata(cache_rdata), .wb(wb), .ptr_wb(ptr_wb), .flags(flags));
  lsst_cache_model lsst_cache_model_inst (.clk(clk), .cache_req(cache_req),
    .cache_rdata(cache_rdata));

  task automatic conclude();
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    conclude();
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic lsst_issue_t mk(input lsst_op_t op, input lsst_amode_t am,
    input logic [31:0] disp, input logic [31:0] idx, input logic [4:0] sa);
    lsst_issue_t i;
    i = '0;
    i.op = op;
    i.amode = am;
    i.ptr_val = 32'h100;
    i.disp = disp;
    i.idx_val = idx;
    i.shift_amount = sa;
    i.dst = 4'h2;
    i.opa = 32'h11223344;
    i.sdata = 64'h5566778811223344;
    return i;
  endfunction

  // hold the request from a falling edge until a rising edge takes it
  task automatic issue(input lsst_issue_t i);
    int k;
    in_valid = 1'b1;
    in_instr = i;
    for (k = 0; k < 20; k++)
    begin
      #1;
      if (in_ready === 1'b1)
        break;
      @(negedge clk);
    end
    if (k == 20)
      hang();
    @(posedge clk);
    @(negedge clk);
    t_iss = cyc;
  endtask

  // count cycles after the issue edge until result or store access shows
  task automatic run(input lsst_issue_t i, input bit st);
    int k;
    issue(i);
    in_valid = 1'b0;
    flat = -1;
    for (k = 1; k <= 12; k++)
    begin
      if (flags.valid === 1'b1 && flat < 0)
      begin
        flat = k;
        fq = {flags.q, flags.n, flags.z};
      end
      if (st ? cache_req.valid === 1'b1 : wb.valid === 1'b1)
        break;
      @(negedge clk);
    end
    if (k > 12)
      hang();
    lat = k;
    wd = st ? cache_req.wdata : wb.data;
  endtask

  task automatic sat(input lsst_op_t op, input logic [31:0] a, input logic [31:0] b,
    input logic [4:0] sa, input logic [4:0] cb, input logic [31:0] exp, input logic q);
    lsst_issue_t i;
    i = mk(op, am_plain, 32'h0, 32'h0, sa);
    i.opa = a;
    i.opb = b;
    i.clamp_bit_position = cb;
    run(i, 1'b0);
    check(64'(lat), 64'h2);
    check(64'(flat), 64'h1);
    check({32'h0, wd[31:0]}, {32'h0, exp});
    check({61'h0, fq}, {61'h0, q, exp[31], exp == 32'h0});
  endtask

  task automatic ld(input lsst_op_t op, input lsst_amode_t am, input logic [31:0] disp,
    input logic [31:0] idx, input logic [4:0] sa, input logic [1:0] part, input int n,
    input logic [63:0] exp);
    lsst_issue_t i;
    i = mk(op, am, disp, idx, sa);
    i.part = part;
    run(i, 1'b0);
    check(64'(lat), 64'(n));
    check(op == op_load_doubleword ? wd : {32'h0, wd[31:0]}, exp);
  endtask

  task automatic st(input lsst_op_t op, input logic [31:0] disp, input int n,
    input logic [63:0] m, input logic [63:0] exp);
    run(mk(op, am_disp, disp, 32'h0, 5'h0), 1'b1);
    check(64'(lat), 64'(n));
    check(wd & m, exp);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_sat();
    sat(op_sat_add_w, 32'h7fffffff, 32'h1, 5'h0, 5'h0, 32'h7fffffff, 1'b1);
    sat(op_sat_sub_w, 32'h80000000, 32'h1, 5'h0, 5'h0, 32'h80000000, 1'b1);
    sat(op_sat_add_h, 32'h7fff, 32'h1, 5'h0, 5'h0, 32'h7fff, 1'b1);
    sat(op_sat_sub_h, 32'h1, 32'h1, 5'h0, 5'h0, 32'h0, 1'b0);
    sat(op_sat_rnd_s, 32'h7ff0, 32'h0, 5'h4, 5'h8, 32'h7f, 1'b1);
    sat(op_sat_rnd_s, 32'h138, 32'h0, 5'h4, 5'h8, 32'h14, 1'b0);
    sat(op_sat_rnd_u, 32'h1ff8, 32'h0, 5'h4, 5'h8, 32'hff, 1'b1);
    sat(op_sat_shift_s, 32'hffff0000, 32'h0, 5'h8, 5'h8, 32'hffffff80, 1'b1);
    sat(op_sat_shift_u, 32'hfffffff0, 32'h0, 5'h0, 5'h8, 32'h0, 1'b1);
    sat(op_sat_shift_u, 32'h500, 32'h0, 5'h4, 5'h8, 32'h50, 1'b0);
  endtask

  task automatic t_loads();
    ld(op_load_unsigned_byte, am_disp, 32'h0, 32'h0, 5'h0, 2'h0, 3, 64'h8c);
    ld(op_load_signed_byte, am_disp, 32'h0, 32'h0, 5'h0, 2'h0, 3, 64'hffffff8c);
    ld(op_load_unsigned_half, am_disp, 32'h0, 32'h0, 5'h0, 2'h0, 3, 64'h8d8c);
    ld(op_load_signed_half, am_disp, 32'h0, 32'h0, 5'h0, 2'h0, 3, 64'hffff8d8c);
    ld(op_load_word, am_disp, 32'h0, 32'h0, 5'h0, 2'h0, 2, 64'h8c8c8d8c);
    ld(op_load_word, am_disp, 32'h1, 32'h0, 5'h0, 2'h0, 4, 64'h8c8c8d8d);
    ld(op_load_word, am_disp, 32'h2, 32'h0, 5'h0, 2'h0, 3, 64'h8c8c8d8e);
    ld(op_load_doubleword, am_disp, 32'h0, 32'h0, 5'h0, 2'h0, 2, 64'h111112118c8c8d8c);
    ld(op_load_doubleword, am_post_inc, 32'h0, 32'h0, 5'h0, 2'h0, 2, 64'h111112118c8c8d8c);
    ld(op_load_doubleword, am_pre_dec, 32'h0, 32'h0, 5'h0, 2'h0, 2, 64'h111112098c8c8c74);
    ld(op_load_doubleword, am_disp, 32'h4, 32'h0, 5'h0, 2'h0, 3, 64'h111112158c8c8d88);
    ld(op_load_unsigned_byte, am_indexed, 32'h0, 32'h4, 5'h2, 2'h0, 3, 64'h9c);
    ld(op_load_word, am_ext_index, 32'h0, 32'h300, 5'h0, 2'h1, 2, 64'h8c8c8d80);
    ld(op_load_insert_byte, am_disp, 32'h0, 32'h0, 5'h0, 2'h2, 3, 64'h118c3344);
    ld(op_load_insert_half, am_disp, 32'h0, 32'h0, 5'h0, 2'h1, 3, 64'h8d8c3344);
    ld(op_load_swap_word, am_disp, 32'h0, 32'h0, 5'h0, 2'h0, 3, 64'h8c8d8c8c);
    ld(op_load_swap_signed_half, am_disp, 32'h0, 32'h0, 5'h0, 2'h0, 3, 64'hffff8c8d);
    ld(op_load_swap_unsigned_half, am_disp, 32'h0, 32'h0, 5'h0, 2'h0, 3, 64'h8c8d);
  endtask

  task automatic t_store();
    st(op_store_word, 32'h0, 1, 64'hffffffff, 64'h11223344);
    st(op_store_word, 32'h1, 3, 64'hffffffff, 64'h11223344);
    st(op_store_word, 32'h2, 2, 64'hffffffff, 64'h11223344);
    st(op_store_swap_word, 32'h0, 1, 64'hffffffff, 64'h44332211);
    st(op_store_swap_half, 32'h0, 1, 64'hffff, 64'h4433);
    st(op_store_doubleword, 32'h0, 1, '1, 64'h5566778811223344);
    st(op_store_doubleword, 32'h4, 2, '1, 64'h5566778811223344);
  endtask

  // a writer of a stored register, then a reader of a late load result
  task automatic t_hazard();
    lsst_issue_t p;
    lsst_issue_t c;
    int t0;
    p = mk(op_store_word, am_disp, 32'h0, 32'h0, 5'h0);
    p.src_a = 4'h5;
    c = mk(op_sat_add_w, am_plain, 32'h0, 32'h0, 5'h0);
    c.dst = 4'h5;
    issue(p);
    t0 = t_iss;
    issue(c);
    check(64'(t_iss - t0), 64'h2);
    p = mk(op_load_unsigned_byte, am_disp, 32'h0, 32'h0, 5'h0);
    p.dst = 4'h6;
    c.dst = 4'h2;
    c.src_a = 4'h6;
    c.src_used = 2'h1;
    issue(p);
    t0 = t_iss;
    issue(c);
    in_valid = 1'b0;
    check(64'(t_iss - t0 >= 3), 64'h1);
    repeat (6) @(negedge clk);
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    rst_n = 1'b0;
    in_valid = 1'b0;
    in_instr = '0;
    repeat (5) @(negedge clk);
    check({62'h0, in_ready, wb.valid}, 64'h2);
    rst_n = 1'b1;
    t_sat();
    t_loads();
    t_store();
    t_hazard();
    conclude();
  end
endmodule
